// ---- logic/cgctl_params.svh ----
// Register offsets, field positions, reset values and timing counts of the clock generator control
`ifndef CGCTL_PARAMS_SVH
`define CGCTL_PARAMS_SVH
`define CGCTL_OFF_CTRL1 12'h000
`define CGCTL_OFF_CTRL2 12'h004
`define CGCTL_OFF_STAT 12'h008
`define CGCTL_C1_GAIN 7
`define CGCTL_C1_RANGE 6
`define CGCTL_C1_REFSEL 5
`define CGCTL_C1_MODE_HI 4
`define CGCTL_C1_MODE_LO 3
`define CGCTL_C1_OSCEN 2
`define CGCTL_C1_CLOCK_LOSS_DETECT_DISABLE 1
`define CGCTL_C2_LOLACT 7
`define CGCTL_C2_MULT_HI 6
`define CGCTL_C2_MULT_LO 4
`define CGCTL_C2_LOCACT 3
`define CGCTL_C2_DIV_HI 2
`define CGCTL_C2_DIV_LO 0
`define CGCTL_CTRL1_RST 8'h00
`define CGCTL_CTRL2_RST 8'h00
`define CGCTL_P_LOW 7'h40
`define CGCTL_P_HIGH 7'h01
`define CGCTL_N_BASE 5'h04
`define CGCTL_SETTLE_NS 20
`define CGCTL_CLK_MHZ 200
`define CGCTL_SETTLE_CYC ((`CGCTL_SETTLE_NS * `CGCTL_CLK_MHZ + 999) / 1000)
`endif

// ---- logic/cgctl_pkg.sv ----
// Types shared by the clock generator control block
package cgctl_pkg;
  typedef enum logic [1:0] {
    CGCTL_MODE_SELF = 2'h0,
    CGCTL_MODE_LOOP_INT = 2'h1,
    CGCTL_MODE_BYPASS_EXT = 2'h2,
    CGCTL_MODE_LOOP_EXT = 2'h3
  } cgctl_mode_t;
endpackage

// ---- logic/cgctl_top.sv ----
// Clock generator control registers behind an AHB-Lite slave
// How it works
// - Gain bit picks low power or high gain
// - Gain, range, reference bits write once
// - Range bit picks prescale 64 or 1
// - Range matters only in external modes
// - Reference bit picks external clock or crystal
// - Mode field encodes four clock modes
// - Bypass mode waits for external reference ok
// - Off mode keeps stored mode field
// - Mode, multiplier and divider writes dropped while previous write of that field pending
// - First mode 0X locks out 1X
// - Off-mode oscillator bit ignored at high gain/range
// - Off-mode oscillator enable conditions
// - Loss-of-clock detect disable bit
// - Lock-loss action applies while sticky flag set
// - Multiplier field sets factor N
// - Clock-loss action picks interrupt or reset
// - Divider field sets factor R
// - Reference ok flag reflects stable external clock
// - Reference status shows selected reference kind
`include "cgctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cgctl_top
  import cgctl_pkg::*;
#(
  parameter int SETTLE_CYC = `CGCTL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [11:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HWDATA_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Clock generator status inputs (asynchronous)
  input wire logic EXT_REF_STABLE_I,
  input wire logic LOCK_LOST_STICKY_I,
  input wire logic CLOCK_LOST_I,
  input wire logic STOP_OFF_I,
  input wire logic OSC_ENABLE_REQ_I,
  // Clock generator controls
  output logic OSC_HIGH_GAIN_O,
  output logic OSC_HIGH_RANGE_O,
  output logic [6:0] PRESCALE_P_O,
  output logic OSC_CRYSTAL_O,
  output logic [1:0] ACTIVE_MODE_O,
  output logic OSC_ENABLE_O,
  output logic CLOCK_LOSS_DETECT_EN_O,
  output logic [4:0] MULT_N_O,
  output logic [7:0] DIV_R_O,
  output logic LOCK_LOSS_IRQ_O,
  output logic LOCK_LOSS_RESET_O,
  output logic CLOCK_LOSS_IRQ_O,
  output logic CLOCK_LOSS_RESET_O
);

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic first1_done;
    logic ext_locked_out;
    logic ph_wr;
    logic [11:0] ph_addr;
    logic [1:0] act_mode;
    logic [1:0] mode_tgt;
    logic [2:0] mult_act;
    logic [2:0] div_act;
    logic [7:0] mode_cnt;
    logic [7:0] mult_cnt;
    logic [7:0] div_cnt;
    logic [1:0] s_ok;
    logic [1:0] s_lol;
    logic [1:0] s_loc;
    logic [1:0] s_stop;
    logic [1:0] s_oen;
    logic [31:0] rdata;
    logic [6:0] p_q;
    logic [4:0] n_q;
    logic [7:0] r_q;
    logic osc_en;
    logic lol_irq;
    logic lol_rst;
    logic loc_irq;
    logic loc_rst;
  } cgctl_state_t;

  localparam logic [7:0] SETTLE = 8'(SETTLE_CYC);

  cgctl_state_t s_q, s_d;

  // Word-aligned decode, used for writes and reads
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    if (a == `CGCTL_OFF_CTRL1) begin
      reg_sel = 2'h1;
    end else if (a == `CGCTL_OFF_CTRL2) begin
      reg_sel = 2'h2;
    end else if (a == `CGCTL_OFF_STAT) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  logic addr_ok;
  logic ref_ok;
  logic [7:0] w;
  logic [1:0] new_mode;
  logic [1:0] rsel;

  // Next-state logic: bus, write rules, mode switching and decoded outputs
  always_comb begin
    s_d = s_q;
    addr_ok = 1'b0;
    w = HWDATA_I[7:0];
    new_mode = w[`CGCTL_C1_MODE_HI:`CGCTL_C1_MODE_LO];
    rsel = reg_sel(s_q.ph_addr);
    // Synchronisers: first stage feeds only the second
    s_d.s_ok = {s_q.s_ok[0], EXT_REF_STABLE_I};
    s_d.s_lol = {s_q.s_lol[0], LOCK_LOST_STICKY_I};
    s_d.s_loc = {s_q.s_loc[0], CLOCK_LOST_I};
    s_d.s_stop = {s_q.s_stop[0], STOP_OFF_I};
    s_d.s_oen = {s_q.s_oen[0], OSC_ENABLE_REQ_I};
    ref_ok = s_q.s_ok[1];

    // Address phase capture
    s_d.ph_wr = 1'b0;
    if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
      addr_ok = (HSIZE_I == 3'h2);
      s_d.ph_wr = HWRITE_I && addr_ok;
      s_d.ph_addr = HADDR_I;
    end

    // Data phase writes
    if (s_q.ph_wr && rsel == 2'h1) begin
      if (!s_q.first1_done) begin
        s_d.ctrl1[7:5] = w[7:5];
        s_d.first1_done = 1'b1;
        s_d.ext_locked_out = !new_mode[1];
      end
      s_d.ctrl1[2:1] = w[2:1];
      // Mode accepted if nothing pending and, for an external mode, not locked out by the first write
      if (s_q.mode_cnt == 8'h00 && !(new_mode[1] && (s_q.first1_done ? s_q.ext_locked_out : 1'b0))) begin
        s_d.ctrl1[4:3] = new_mode;
        s_d.mode_cnt = SETTLE;
      end
    end
    if (s_q.ph_wr && rsel == 2'h2) begin
      s_d.ctrl2[7] = w[7];
      s_d.ctrl2[3] = w[3];
      if (s_q.mult_cnt == 8'h00) begin
        s_d.ctrl2[6:4] = w[6:4];
        s_d.mult_cnt = SETTLE;
      end
      if (s_q.div_cnt == 8'h00) begin
        s_d.ctrl2[2:0] = w[2:0];
        s_d.div_cnt = SETTLE;
      end
    end

    // Pending writes complete after the settle count
    if (s_q.mode_cnt != 8'h00) begin
      s_d.mode_cnt = s_q.mode_cnt - 8'h01;
    end
    if (s_q.mult_cnt != 8'h00) begin
      s_d.mult_cnt = s_q.mult_cnt - 8'h01;
    end else begin
      s_d.mult_act = s_q.ctrl2[6:4];
    end
    if (s_q.div_cnt != 8'h00) begin
      s_d.div_cnt = s_q.div_cnt - 8'h01;
    end else begin
      s_d.div_act = s_q.ctrl2[2:0];
    end

    // Active mode follows requested mode; off mode freezes it, stored field stays
    s_d.mode_tgt = s_q.ctrl1[4:3];
    if (!s_q.s_stop[1] && s_q.mode_cnt == 8'h00) begin
      if (s_q.mode_tgt == CGCTL_MODE_BYPASS_EXT) begin
        if (ref_ok) begin
          s_d.act_mode = s_q.mode_tgt;
        end
      end else begin
        s_d.act_mode = s_q.mode_tgt;
      end
    end

    // Prescale only meaningful in external modes
    if (s_q.act_mode[1]) begin
      s_d.p_q = s_q.ctrl1[`CGCTL_C1_RANGE] ? `CGCTL_P_HIGH : `CGCTL_P_LOW;
    end else begin
      s_d.p_q = `CGCTL_P_HIGH;
    end
    s_d.n_q = `CGCTL_N_BASE + {1'b0, s_q.mult_act, 1'b0};
    s_d.r_q = 8'h01 << s_q.div_act;

    // Oscillator enable, including off-mode behaviour
    if (!s_q.s_stop[1]) begin
      s_d.osc_en = s_q.ctrl1[4] && s_q.ctrl1[`CGCTL_C1_REFSEL];
    end else if (s_q.ctrl1[7] && s_q.ctrl1[6]) begin
      s_d.osc_en = s_q.s_oen[1] && s_q.ctrl1[4:3] == 2'h2 && s_q.ctrl1[5];
    end else if (s_q.ctrl1[`CGCTL_C1_OSCEN]) begin
      s_d.osc_en = s_q.ctrl1[4] && s_q.ctrl1[5];
    end else begin
      s_d.osc_en = s_q.s_oen[1] && s_q.ctrl1[4:3] == 2'h2 && s_q.ctrl1[5];
    end

    // Loss events steered to interrupt or reset request
    s_d.lol_irq = s_q.s_lol[1] && !s_q.ctrl2[`CGCTL_C2_LOLACT];
    s_d.lol_rst = s_q.s_lol[1] && s_q.ctrl2[`CGCTL_C2_LOLACT];
    s_d.loc_irq = s_q.s_loc[1] && !s_q.ctrl1[1] && !s_q.ctrl2[`CGCTL_C2_LOCACT];
    s_d.loc_rst = s_q.s_loc[1] && !s_q.ctrl1[1] && s_q.ctrl2[`CGCTL_C2_LOCACT];

    // Read data registered in the address phase
    s_d.rdata = 32'h0;
    if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
      case (reg_sel(HADDR_I))
        2'h1: s_d.rdata = {24'h0, s_q.ctrl1};
        2'h2: s_d.rdata = {24'h0, s_q.ctrl2};
        2'h3: s_d.rdata = {24'h0, s_q.act_mode, s_q.ctrl1[5], s_q.s_lol[1], 2'h0, ref_ok, 1'b0};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      s_q <= '0;
      s_q.ctrl1 <= `CGCTL_CTRL1_RST;
      s_q.ctrl2 <= `CGCTL_CTRL2_RST;
      s_q.p_q <= `CGCTL_P_HIGH;
      s_q.n_q <= `CGCTL_N_BASE;
      s_q.r_q <= 8'h01;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = s_q.rdata;
  assign OSC_HIGH_GAIN_O = s_q.ctrl1[`CGCTL_C1_GAIN];
  assign OSC_HIGH_RANGE_O = s_q.ctrl1[`CGCTL_C1_RANGE];
  assign PRESCALE_P_O = s_q.p_q;
  assign OSC_CRYSTAL_O = s_q.ctrl1[`CGCTL_C1_REFSEL];
  assign ACTIVE_MODE_O = s_q.act_mode;
  assign OSC_ENABLE_O = s_q.osc_en;
  assign CLOCK_LOSS_DETECT_EN_O = !s_q.ctrl1[`CGCTL_C1_CLOCK_LOSS_DETECT_DISABLE];
  assign MULT_N_O = s_q.n_q;
  assign DIV_R_O = s_q.r_q;
  assign LOCK_LOSS_IRQ_O = s_q.lol_irq;
  assign LOCK_LOSS_RESET_O = s_q.lol_rst;
  assign CLOCK_LOSS_IRQ_O = s_q.loc_irq;
  assign CLOCK_LOSS_RESET_O = s_q.loc_rst;

endmodule
`default_nettype wire

// ---- sim/cgctl_assertions.sv ----
// Port-level checks of the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module cgctl_assertions (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // Observed ports
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic EXT_REF_STABLE_I,
  input wire logic STOP_OFF_I,
  input wire logic LOCK_LOST_STICKY_I,
  input wire logic CLOCK_LOST_I,
  input wire logic OSC_HIGH_GAIN_O,
  input wire logic OSC_HIGH_RANGE_O,
  input wire logic [6:0] PRESCALE_P_O,
  input wire logic [1:0] ACTIVE_MODE_O,
  input wire logic CLOCK_LOSS_DETECT_EN_O,
  input wire logic [4:0] MULT_N_O,
  input wire logic [7:0] DIV_R_O,
  input wire logic LOCK_LOSS_IRQ_O,
  input wire logic LOCK_LOSS_RESET_O,
  input wire logic CLOCK_LOSS_IRQ_O,
  input wire logic CLOCK_LOSS_RESET_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Zero wait states, always OKAY
  bus_okay_a: assert property (HREADYOUT_O && !HRESP_O) else $error("bus answer not ready or not okay");
  // Prescale follows range only in the external modes
  prescale_a: assert property ($stable(ACTIVE_MODE_O) && $stable(OSC_HIGH_RANGE_O) |->
    PRESCALE_P_O == ((ACTIVE_MODE_O[1] && !OSC_HIGH_RANGE_O) ? 7'h40 : 7'h01)) else $error("prescale wrong");
  mult_even_a: assert property (!MULT_N_O[0] && MULT_N_O >= 5'h04 && MULT_N_O <= 5'h12)
    else $error("multiplier out of set");
  div_pow_a: assert property ($onehot(DIV_R_O)) else $error("divider not a power of two");
  // Bypass entered only on a settled reference
  bypass_wait_a: assert property ($changed(ACTIVE_MODE_O) && ACTIVE_MODE_O == 2'h2 |->
    $past(EXT_REF_STABLE_I, 2)) else $error("bypass entered without reference");
  off_freeze_a: assert property (STOP_OFF_I [*4] |=> $stable(ACTIVE_MODE_O))
    else $error("mode moved in off mode");
  once_bits_a: assert property (!$fell(OSC_HIGH_GAIN_O) && !$fell(OSC_HIGH_RANGE_O))
    else $error("write-once bit cleared");
  lock_act_a: assert property (LOCK_LOST_STICKY_I [*5] |-> LOCK_LOSS_IRQ_O != LOCK_LOSS_RESET_O)
    else $error("lock loss action not single");
  lock_idle_a: assert property ((!LOCK_LOST_STICKY_I) [*5] |-> !LOCK_LOSS_IRQ_O && !LOCK_LOSS_RESET_O)
    else $error("lock loss action without flag");
  clk_act_a: assert property ((CLOCK_LOST_I && CLOCK_LOSS_DETECT_EN_O) [*5] |->
    CLOCK_LOSS_IRQ_O != CLOCK_LOSS_RESET_O) else $error("clock loss action not single");
endmodule
`default_nettype wire

// ---- sim/cgctl_ext_src.sv ----
// Behavioural external clock source that reports when it has settled
`timescale 1ns/1ps
`default_nettype none
module cgctl_ext_src (
  // Clock and control
  input wire logic clk_i,
  input wire logic present_i,
  // Status towards the block
  output logic stable_o
);
  logic [3:0] cnt_q = 4'h0;
  // Settling takes 8 cycles; removal drops the flag at once
  always @(posedge clk_i) begin
    cnt_q <= present_i ? cnt_q + {3'h0, cnt_q != 4'h8} : 4'h0;
  end
  assign stable_o = (cnt_q == 4'h8);
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Register-level tests of the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cgctl_pkg::*;
  logic REF_CLK_I = 0, RST_N_I = 0, HSEL_I = 0, HWRITE_I = 0, src_on = 0;
  logic HREADY_I;
  logic [11:0] HADDR_I = 12'h000;
  logic [1:0] HTRANS_I = 2'h0, ACTIVE_MODE_O;
  logic [2:0] HSIZE_I = 3'h2;
  logic [31:0] HWDATA_I = 32'h0, HRDATA_O, rdat;
  logic HREADYOUT_O, HRESP_O, EXT_REF_STABLE_I, OSC_HIGH_GAIN_O, OSC_HIGH_RANGE_O, OSC_CRYSTAL_O, OSC_ENABLE_O;
  logic LOCK_LOST_STICKY_I = 0, CLOCK_LOST_I = 0, STOP_OFF_I = 0, OSC_ENABLE_REQ_I = 0, CLOCK_LOSS_DETECT_EN_O;
  logic LOCK_LOSS_IRQ_O, LOCK_LOSS_RESET_O, CLOCK_LOSS_IRQ_O, CLOCK_LOSS_RESET_O;
  logic [6:0] PRESCALE_P_O;
  logic [4:0] MULT_N_O;
  logic [7:0] DIV_R_O;
  int n_mismatch = 0, n_tests = 0;
  // The single slave's ready is the bus ready
  assign HREADY_I = HREADYOUT_O;
  cgctl_top i_dut (.*);
  cgctl_ext_src i_src (.clk_i(REF_CLK_I), .present_i(src_on), .stable_o(EXT_REF_STABLE_I));
  // 200 MHz clock
  initial forever #2.5 REF_CLK_I = ~REF_CLK_I;
  task automatic w(input int n);
    repeat (n) @(posedge REF_CLK_I);
  endtask
  // One single word transfer; the slave may stretch either phase
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    HSEL_I <= 1'b1; HTRANS_I <= 2'h2; HWRITE_I <= wr; HADDR_I <= a;
    do @(posedge REF_CLK_I); while (HREADYOUT_O !== 1'b1);
    HSEL_I <= 1'b0; HTRANS_I <= 2'h0; HWDATA_I <= wd;
    do @(posedge REF_CLK_I); while (HREADYOUT_O !== 1'b1);
    rdat = HRDATA_O;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    w(20000);
    n_mismatch++;
    results();
  end
  // Main sequence
  initial begin
    w(20);
    RST_N_I <= 1'b1;
    w(1);
    chk("mult reset", MULT_N_O, 4);
    ahb(1, 12'h000, 32'hb8);
    ahb(1, 12'h000, 32'h58);
    ahb(0, 12'h000, 0);
    chk("ctrl1 once", rdat, 32'hb8);
    w(12);
    chk("gain", OSC_HIGH_GAIN_O, 1);
    chk("crystal", OSC_CRYSTAL_O, 1);
    chk("mode", ACTIVE_MODE_O, CGCTL_MODE_LOOP_EXT);
    chk("prescale", PRESCALE_P_O, 64);
    ahb(1, 12'h000, 32'hb0);
    w(15);
    chk("no bypass", ACTIVE_MODE_O, CGCTL_MODE_LOOP_EXT);
    src_on <= 1'b1;
    w(20);
    chk("bypass", ACTIVE_MODE_O, CGCTL_MODE_BYPASS_EXT);
    ahb(0, 12'h008, 0);
    chk("status", rdat, 32'ha2);
    chk("osc on", OSC_ENABLE_O, 1);
    chk("range", OSC_HIGH_RANGE_O, 0);
    $display("test modes done");
    LOCK_LOST_STICKY_I <= 1'b1;
    CLOCK_LOST_I <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      ahb(1, 12'h004, {24'h0, c[0], c[2:0], c[0], c[2:0]});
      w(10);
      chk("mult", MULT_N_O, 4 + 2 * c);
      chk("div", DIV_R_O, 1 << c);
      chk("lock act", LOCK_LOSS_RESET_O, c[0]);
      chk("clock act", CLOCK_LOSS_RESET_O, c[0]);
      chk("lock irq", LOCK_LOSS_IRQ_O, !c[0]);
      chk("clock irq", CLOCK_LOSS_IRQ_O, !c[0]);
    end
    ahb(1, 12'h004, 32'h10);
    ahb(1, 12'h004, 32'h20);
    w(10);
    chk("pending", MULT_N_O, 6);
    ahb(0, 12'h00c, 0);
    chk("unmapped", rdat, 0);
    $display("test factors done");
    RST_N_I <= 1'b0;
    w(2);
    RST_N_I <= 1'b1;
    w(1);
    ahb(1, 12'h000, 32'h0a);
    w(10);
    ahb(1, 12'h000, 32'h1a);
    w(10);
    ahb(0, 12'h000, 0);
    chk("ctrl1 lock", rdat, 32'h0a);
    chk("detect", CLOCK_LOSS_DETECT_EN_O, 0);
    chk("loss off", CLOCK_LOSS_IRQ_O, 0);
    STOP_OFF_I <= 1'b1;
    w(6);
    ahb(1, 12'h000, 32'h02);
    w(10);
    chk("frozen", ACTIVE_MODE_O, CGCTL_MODE_LOOP_INT);
    STOP_OFF_I <= 1'b0;
    w(12);
    chk("self", ACTIVE_MODE_O, CGCTL_MODE_SELF);
    $display("test lockout done");
    results();
  end
endmodule
bind cgctl_top cgctl_assertions i_chk (.*);
`default_nettype wire
